/* hw/phybmc_pkg.sv */
/*
  Constants and types for the basic mode control and status register pair of a
  10/100 Ethernet PHY, reached over the serial management interface.
  Assumes a single 20 MHz clock and management pins taken as synchronous to it.
*/
// Functional notes
// - Isolate bit disconnects port, management stays alive.
// - Restart write ignored while autoneg disabled.
// - Restart reads one until negotiation starts.
// - Writing restart zero leaves negotiation running.
// - Duplex bit, strap default, used when forced.
// - Collision test raises collision within 512 bits.
// - Collision test drops collision within 4 bits.
// - Status bit 15 always reads zero.
// - Status bits 14 to 11 read one.
// - Preamble suppression bit one, preamble rules.
// - Autoneg complete only when negotiation finished.
// - Remote fault latches high, cleared by read.
// - Autoneg ability bit reads one.
// - Link status latches low until read.
// - Jabber latches high, meaningful at 10 Mbps.
// - Extended capability bit reads one.
// - Latched bits hold their value until read.
// - Autoneg off: bits 8, 13 force mode.

`default_nettype none

package phybmc_pkg;

  // Management register addresses.
  localparam logic [4:0] REG_CTRL_ADDR = 5'h00;
  localparam logic [4:0] REG_STAT_ADDR = 5'h01;

  // Control register field positions.
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_AN_EN_BIT   = 12;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_COLTEST_BIT = 7;

  // Control register reset values, before the straps are taken.
  localparam logic CTRL_SPEED_RST   = 1'b1;
  localparam logic CTRL_AN_EN_RST   = 1'b1;
  localparam logic CTRL_ISOLATE_RST = 1'b0;
  localparam logic CTRL_RESTART_RST = 1'b0;
  localparam logic CTRL_DUPLEX_RST  = 1'b1;
  localparam logic CTRL_COLTEST_RST = 1'b0;

  // Status register field positions.
  localparam int STAT_T4_BIT      = 15;
  localparam int STAT_TX_FD_BIT   = 14;
  localparam int STAT_TX_HD_BIT   = 13;
  localparam int STAT_TE_FD_BIT   = 12;
  localparam int STAT_TE_HD_BIT   = 11;
  localparam int STAT_PRE_SUP_BIT = 6;
  localparam int STAT_AN_CMP_BIT  = 5;
  localparam int STAT_RFAULT_BIT  = 4;
  localparam int STAT_AN_ABL_BIT  = 3;
  localparam int STAT_LINK_BIT    = 2;
  localparam int STAT_JABBER_BIT  = 1;
  localparam int STAT_EXT_BIT     = 0;

  // Fixed status values and latch reset values.
  localparam logic STAT_T4_VAL      = 1'b0;
  localparam logic STAT_CAP_VAL     = 1'b1;
  localparam logic STAT_PRE_SUP_VAL = 1'b1;
  localparam logic STAT_AN_ABL_VAL  = 1'b1;
  localparam logic STAT_EXT_VAL     = 1'b1;
  localparam logic STAT_RFAULT_RST  = 1'b0;
  localparam logic STAT_LINK_RST    = 1'b0;
  localparam logic STAT_JABBER_RST  = 1'b0;

  // Management frame fields.
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [4:0] OP_LAST       = 5'h01;
  localparam logic [4:0] ADDR_LAST     = 5'h09;
  localparam logic [4:0] DATA_LAST     = 5'h0f;
  localparam logic [4:0] SKIP_LAST     = 5'h11;

  // Management frame receiver states.
  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_OP,
    S_ADDR,
    S_TA,
    S_DATA,
    S_SKIP
  } phybmc_state_e;

endpackage

`default_nettype wire

/* hw/phybmc_top.sv */
/*
  Basic mode control and status registers with their management frame slave.
  Assumes mdc and mdio_in are synchronous to clk and that mdc runs well below
  clk / 2; the auto-negotiation engine and link monitors sit outside.
*/
`timescale 1ns/1ps
`default_nettype none

module phybmc_top (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  input  wire logic [4:0] phy_addr,
  input  wire logic       strap_speed_100,
  input  wire logic       strap_an_enable,
  input  wire logic       strap_full_duplex,
  input  wire logic       tx_en,
  input  wire logic       link_up,
  input  wire logic       far_end_fault,
  input  wire logic       partner_remote_fault,
  input  wire logic       jabber_detected,
  input  wire logic       an_done,
  input  wire logic       an_started,
  input  wire logic       an_speed_100,
  input  wire logic       an_full_duplex,
  output logic            mac_isolate,
  output logic            an_restart_req,
  output logic            an_enable,
  output logic            port_speed_100,
  output logic            port_full_duplex,
  output logic            col
);

  logic                       mdc_q;
  logic                       mdc_rise;
  phybmc_pkg::phybmc_state_e  state;
  logic [4:0]                 bit_cnt;
  logic [15:0]                in_sh;
  logic [15:0]                out_sh;
  logic [1:0]                 op;
  logic [4:0]                 reg_sel;
  logic [5:0]                 pre_cnt;
  logic                       pre_ok;
  logic                       drive;
  logic                       wr_pulse;
  logic [15:0]                wr_data;
  logic [4:0]                 wr_addr;
  logic                       rd_stat;
  logic                       strap_load;
  logic                       speed_sel;
  logic                       duplex_sel;
  logic                       coll_test;
  logic                       rfault_lh;
  logic                       jabber_lh;
  logic                       link_ll;
  logic [15:0]                ctrl_word;
  logic [15:0]                stat_word;
  logic                       wr_ctrl;

  // The management clock is sampled as an ordinary input; work happens on its rise.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end
  assign mdc_rise = mdc & ~mdc_q;
  assign wr_ctrl  = wr_pulse && (wr_addr == phybmc_pkg::REG_CTRL_ADDR);

  // Read images; reserved bits are tied low.
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[phybmc_pkg::CTRL_SPEED_BIT]   = speed_sel;
    ctrl_word[phybmc_pkg::CTRL_AN_EN_BIT]   = an_enable;
    ctrl_word[phybmc_pkg::CTRL_ISOLATE_BIT] = mac_isolate;
    ctrl_word[phybmc_pkg::CTRL_RESTART_BIT] = an_restart_req;
    ctrl_word[phybmc_pkg::CTRL_DUPLEX_BIT]  = duplex_sel;
    ctrl_word[phybmc_pkg::CTRL_COLTEST_BIT] = coll_test;
    stat_word = 16'h0000;
    stat_word[phybmc_pkg::STAT_T4_BIT]      = phybmc_pkg::STAT_T4_VAL;
    stat_word[phybmc_pkg::STAT_TX_FD_BIT]   = phybmc_pkg::STAT_CAP_VAL;
    stat_word[phybmc_pkg::STAT_TX_HD_BIT]   = phybmc_pkg::STAT_CAP_VAL;
    stat_word[phybmc_pkg::STAT_TE_FD_BIT]   = phybmc_pkg::STAT_CAP_VAL;
    stat_word[phybmc_pkg::STAT_TE_HD_BIT]   = phybmc_pkg::STAT_CAP_VAL;
    stat_word[phybmc_pkg::STAT_PRE_SUP_BIT] = phybmc_pkg::STAT_PRE_SUP_VAL;
    stat_word[phybmc_pkg::STAT_AN_CMP_BIT]  = an_done & an_enable;
    stat_word[phybmc_pkg::STAT_RFAULT_BIT]  = rfault_lh;
    stat_word[phybmc_pkg::STAT_AN_ABL_BIT]  = phybmc_pkg::STAT_AN_ABL_VAL;
    stat_word[phybmc_pkg::STAT_LINK_BIT]    = link_ll;
    stat_word[phybmc_pkg::STAT_JABBER_BIT]  = jabber_lh;
    stat_word[phybmc_pkg::STAT_EXT_BIT]     = phybmc_pkg::STAT_EXT_VAL;
  end

  // Frame receiver and read driver. After an invalid opcode or turnaround a full
  // preamble is demanded again, so a confused host resynchronises cleanly.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= phybmc_pkg::S_IDLE;
      bit_cnt  <= 5'h00;
      in_sh    <= 16'h0000;
      out_sh   <= 16'h0000;
      op       <= 2'h0;
      reg_sel  <= 5'h00;
      pre_cnt  <= 6'h00;
      pre_ok   <= 1'b0;
      drive    <= 1'b0;
      mdio_out <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data  <= 16'h0000;
      wr_addr  <= 5'h00;
      rd_stat  <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_stat  <= 1'b0;
      if (mdc_rise) begin
        case (state)
          phybmc_pkg::S_IDLE: begin
            if (mdio_in) begin
              if (pre_cnt != phybmc_pkg::PREAMBLE_BITS) begin
                pre_cnt <= pre_cnt + 6'h01;
              end
            end else begin
              pre_cnt <= 6'h00;
              if (pre_ok || pre_cnt == phybmc_pkg::PREAMBLE_BITS) begin
                state <= phybmc_pkg::S_START;
              end
            end
          end
          phybmc_pkg::S_START: begin
            bit_cnt <= 5'h00;
            state   <= mdio_in ? phybmc_pkg::S_OP : phybmc_pkg::S_IDLE;
          end
          phybmc_pkg::S_OP: begin
            in_sh   <= {in_sh[14:0], mdio_in};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == phybmc_pkg::OP_LAST) begin
              bit_cnt <= 5'h00;
              op      <= {in_sh[0], mdio_in};
              if ({in_sh[0], mdio_in} == phybmc_pkg::OP_READ ||
                  {in_sh[0], mdio_in} == phybmc_pkg::OP_WRITE) begin
                state  <= phybmc_pkg::S_ADDR;
                pre_ok <= 1'b1;
              end else begin
                state  <= phybmc_pkg::S_IDLE;
                pre_ok <= 1'b0;
              end
            end
          end
          phybmc_pkg::S_ADDR: begin
            in_sh   <= {in_sh[14:0], mdio_in};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == phybmc_pkg::ADDR_LAST) begin
              bit_cnt <= 5'h00;
              reg_sel <= {in_sh[3:0], mdio_in};
              if (in_sh[8:4] != phy_addr) begin
                state <= phybmc_pkg::S_SKIP;
              end else begin
                state <= phybmc_pkg::S_TA;
                if (op == phybmc_pkg::OP_READ) begin
                  // The read snapshot is the moment latched bits count as read.
                  case ({in_sh[3:0], mdio_in})
                    phybmc_pkg::REG_CTRL_ADDR: out_sh <= ctrl_word;
                    phybmc_pkg::REG_STAT_ADDR: begin
                      out_sh  <= stat_word;
                      rd_stat <= 1'b1;
                    end
                    default: out_sh <= 16'h0000;
                  endcase
                end
              end
            end
          end
          phybmc_pkg::S_TA: begin
            bit_cnt <= 5'h01;
            if (bit_cnt == 5'h00) begin
              if (op == phybmc_pkg::OP_READ) begin
                drive    <= 1'b1;
                mdio_out <= 1'b0;
              end else if (!mdio_in) begin
                state  <= phybmc_pkg::S_IDLE;
                pre_ok <= 1'b0;
              end
            end else begin
              bit_cnt <= 5'h00;
              if (op == phybmc_pkg::OP_READ) begin
                mdio_out <= out_sh[15];
                out_sh   <= {out_sh[14:0], 1'b0};
                state    <= phybmc_pkg::S_DATA;
              end else if (mdio_in) begin
                state  <= phybmc_pkg::S_IDLE;
                pre_ok <= 1'b0;
              end else begin
                state <= phybmc_pkg::S_DATA;
              end
            end
          end
          phybmc_pkg::S_DATA: begin
            bit_cnt <= bit_cnt + 5'h01;
            in_sh   <= {in_sh[14:0], mdio_in};
            if (op == phybmc_pkg::OP_READ) begin
              mdio_out <= out_sh[15];
              out_sh   <= {out_sh[14:0], 1'b0};
            end
            if (bit_cnt == phybmc_pkg::DATA_LAST) begin
              state    <= phybmc_pkg::S_IDLE;
              drive    <= 1'b0;
              mdio_out <= 1'b0;
              if (op == phybmc_pkg::OP_WRITE) begin
                wr_pulse <= 1'b1;
                wr_addr  <= reg_sel;
                wr_data  <= {in_sh[14:0], mdio_in};
              end
            end
          end
          phybmc_pkg::S_SKIP: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == phybmc_pkg::SKIP_LAST) begin
              state <= phybmc_pkg::S_IDLE;
            end
          end
          default: state <= phybmc_pkg::S_IDLE;
        endcase
      end
    end
  end
  assign mdio_oe_n = ~drive;

  // Straps are taken on the first edge after reset release, never under reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= 1'b0;
    end
  end

  // Writable control bits; status writes and reserved bits fall away.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_sel   <= phybmc_pkg::CTRL_SPEED_RST;
      an_enable   <= phybmc_pkg::CTRL_AN_EN_RST;
      mac_isolate <= phybmc_pkg::CTRL_ISOLATE_RST;
      duplex_sel  <= phybmc_pkg::CTRL_DUPLEX_RST;
      coll_test   <= phybmc_pkg::CTRL_COLTEST_RST;
    end else if (strap_load) begin
      speed_sel  <= strap_speed_100;
      an_enable  <= strap_an_enable;
      duplex_sel <= strap_full_duplex;
    end else if (wr_ctrl) begin
      speed_sel   <= wr_data[phybmc_pkg::CTRL_SPEED_BIT];
      an_enable   <= wr_data[phybmc_pkg::CTRL_AN_EN_BIT];
      mac_isolate <= wr_data[phybmc_pkg::CTRL_ISOLATE_BIT];
      duplex_sel  <= wr_data[phybmc_pkg::CTRL_DUPLEX_BIT];
      coll_test   <= wr_data[phybmc_pkg::CTRL_COLTEST_BIT];
    end
  end

  // Restart request: a new request wins over the engine's start in the same
  // cycle, and a written zero never cancels a negotiation already asked for.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      an_restart_req <= phybmc_pkg::CTRL_RESTART_RST;
    end else if (wr_ctrl && wr_data[phybmc_pkg::CTRL_RESTART_BIT] &&
                 wr_data[phybmc_pkg::CTRL_AN_EN_BIT]) begin
      an_restart_req <= 1'b1;
    end else if (an_started) begin
      an_restart_req <= 1'b0;
    end
  end

  // Latched-high faults: an event in the read cycle wins and survives.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rfault_lh <= phybmc_pkg::STAT_RFAULT_RST;
      jabber_lh <= phybmc_pkg::STAT_JABBER_RST;
    end else begin
      if (far_end_fault || partner_remote_fault) begin
        rfault_lh <= 1'b1;
      end else if (rd_stat) begin
        rfault_lh <= 1'b0;
      end
      if (jabber_detected) begin
        jabber_lh <= 1'b1;
      end else if (rd_stat) begin
        jabber_lh <= 1'b0;
      end
    end
  end

  // Latched-low link: a drop holds zero until a read made while the link is up.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_ll <= phybmc_pkg::STAT_LINK_RST;
    end else if (!link_up) begin
      link_ll <= 1'b0;
    end else if (rd_stat) begin
      link_ll <= 1'b1;
    end
  end

  // Effective port mode: forced bits apply only with negotiation off.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_speed_100   <= phybmc_pkg::CTRL_SPEED_RST;
      port_full_duplex <= phybmc_pkg::CTRL_DUPLEX_RST;
    end else begin
      port_speed_100   <= an_enable ? an_speed_100 : speed_sel;
      port_full_duplex <= an_enable ? an_full_duplex : duplex_sel;
    end
  end

  // Collision test echo is combinational: a 100 Mbps bit time is shorter than a
  // clock period, so a flop could not drop it within 4 bit times.
  assign col = coll_test & tx_en & ~mac_isolate;

endmodule // phybmc_top

`default_nettype wire

/* verification/phybmc_host.sv */
/*
  Station management host model that sends management frames on mdc and mdio.
  Assumes a pull-up on the shared data line and a device that samples mdc on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module phybmc_host (
  input  wire logic clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output logic      mdc,
  output logic      mdio_in
);
  logic host_drv;

  // The device wins while enabled; a released line floats up to one.
  assign mdio_in = mdio_oe_n ? host_drv : mdio_out;

  // The management clock stands low between frames.
  initial begin
    mdc = 1'b0;
    host_drv = 1'b1;
  end

  // One frame, two clk low and two high per bit, read data sampled before each rise.
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    int          j;
    bits = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < (pre ? 64 : 32); i++) begin
      j = pre ? i - 32 : i;
      @(negedge clk);
      mdc = 1'b0;
      host_drv = (j < 0 || (op == 2'b10 && j >= 14)) ? 1'b1 : bits[31 - j];
      @(negedge clk);
      @(negedge clk);
      if (j >= 16) begin
        rd[31 - j] = mdio_in;
      end
      mdc = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0;
    host_drv = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule // phybmc_host
`default_nettype wire

/* verification/phybmc_properties.sv */
/*
  Concurrent checks on the basic mode register block, bound to its top module.
  Assumes one clk domain and the active-high asynchronous reset sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none
module phybmc_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic tx_en,
  input wire logic an_started,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic mac_isolate,
  input wire logic an_restart_req,
  input wire logic an_enable,
  input wire logic port_speed_100,
  input wire logic port_full_duplex,
  input wire logic col
);
  // Everything here lives in the clk domain and sleeps during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  restart_guard_a: assert property ($rose(an_restart_req) |-> an_enable)
    else $error("restart raised with negotiation off");
  restart_hold_a: assert property (an_restart_req && !an_started && !$past(an_started)
    |=> an_restart_req) else $error("restart dropped before negotiation began");
  fdx_auto_a: assert property (an_enable |=> port_full_duplex == $past(an_full_duplex))
    else $error("duplex not taken from negotiation");
  spd_auto_a: assert property (an_enable |=> port_speed_100 == $past(an_speed_100))
    else $error("speed not taken from negotiation");
  ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround bit not driven low");
  // Isolate and autoneg enable may only move while no read is driving.
  ctrl_quiet_a: assert property (($changed(mac_isolate) || $changed(an_enable)) |-> mdio_oe_n)
    else $error("control changed during a read");
  col_idle_a: assert property (!tx_en |-> !col)
    else $error("collision without transmit enable");
  col_iso_a: assert property (mac_isolate |-> !col)
    else $error("collision while isolated");
endmodule // phybmc_properties

bind phybmc_top phybmc_properties phybmc_properties_i (
  .clk(clk), .sys_rst(sys_rst), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .tx_en(tx_en),
  .an_started(an_started), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
  .mac_isolate(mac_isolate), .an_restart_req(an_restart_req), .an_enable(an_enable),
  .port_speed_100(port_speed_100), .port_full_duplex(port_full_duplex), .col(col)
);
`default_nettype wire

/* verification/test_phybmc_top.sv */
/*
  Self-checking testbench for the basic mode register block and its frame slave.
  Assumes the host model in phybmc_host and the bound checker alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module test_phybmc_top;
  logic       clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe_n, tx_en, link_up;
  logic       far_end_fault, partner_remote_fault, jabber_detected, an_done, an_started;
  logic       an_speed_100, an_full_duplex, mac_isolate, an_restart_req, an_enable;
  logic       port_speed_100, port_full_duplex, col;
  logic       strap_speed_100, strap_an_enable, strap_full_duplex;
  int         n_errors, checked;

  phybmc_top phybmc_top_i (.clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h01),
    .strap_speed_100(strap_speed_100), .strap_an_enable(strap_an_enable),
    .strap_full_duplex(strap_full_duplex), .tx_en(tx_en), .link_up(link_up),
    .far_end_fault(far_end_fault), .partner_remote_fault(partner_remote_fault),
    .jabber_detected(jabber_detected), .an_done(an_done), .an_started(an_started),
    .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .mac_isolate(mac_isolate),
    .an_restart_req(an_restart_req), .an_enable(an_enable), .port_speed_100(port_speed_100),
    .port_full_duplex(port_full_duplex), .col(col));
  phybmc_host host_i (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio_in(mdio_in));

  // A 50 ns period gives the 20 MHz system clock.
  always #25 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    host_i.frame(1'b0, 2'b10, 5'h01, ra, 16'h0000, v);
    chk("read data", v, exp);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    host_i.frame(1'b0, 2'b01, 5'h01, ra, d, v);
  endtask

  task automatic t_idle;
    logic [15:0] v;
    host_i.frame(1'b1, 2'b10, 5'h01, 5'h00, 16'h0000, v);
    chk("control after reset", v, 16'h3100);
    rd(5'h01, 16'h7849);
  endtask

  task automatic t_restart;
    an_done = 1'b1;
    rd(5'h01, 16'h7869);
    wr(5'h00, 16'h1200);
    chk("restart request", 16'(an_restart_req), 16'h0001);
    wr(5'h00, 16'h1000);
    rd(5'h00, 16'h1200);
    @(negedge clk) an_started = 1'b1;
    @(negedge clk) an_started = 1'b0;
    rd(5'h00, 16'h1000);
    wr(5'h00, 16'h0200);
    chk("restart ignored", 16'(an_restart_req), 16'h0000);
    rd(5'h01, 16'h7849);
  endtask

  task automatic t_forced;
    wr(5'h00, 16'h0100);
    chk("forced mode", 16'({port_speed_100, port_full_duplex}), 16'h0001);
    wr(5'h00, 16'h2000);
    chk("forced mode", 16'({port_speed_100, port_full_duplex}), 16'h0002);
    wr(5'h00, 16'h1000);
    chk("negotiated mode", 16'({port_speed_100, port_full_duplex}), 16'h0001);
  endtask

  task automatic t_iso;
    wr(5'h00, 16'h04bf);
    rd(5'h00, 16'h0480);
    tx_en = 1'b1;
    chk("isolate", 16'({mac_isolate, col}), 16'h0002);
    wr(5'h00, 16'h0080);
    chk("collision test", 16'(col), 16'h0001);
    tx_en = 1'b0;
    @(negedge clk);
    chk("collision test", 16'(col), 16'h0000);
  endtask

  task automatic t_latch;
    link_up = 1'b1;
    @(negedge clk) {far_end_fault, jabber_detected} = 2'b11;
    @(negedge clk) {far_end_fault, jabber_detected} = 2'b00;
    repeat (20) @(negedge clk);
    rd(5'h01, 16'h785b);
    @(negedge clk) partner_remote_fault = 1'b1;
    @(negedge clk) partner_remote_fault = 1'b0;
    rd(5'h01, 16'h785d);
    link_up = 1'b0;
    repeat (2) @(negedge clk);
    link_up = 1'b1;
    rd(5'h01, 16'h7849);
    rd(5'h01, 16'h784d);
  endtask

  task automatic t_refuse;
    logic [15:0] v;
    rd(5'h05, 16'h0000);
    wr(5'h01, 16'h0000);
    rd(5'h01, 16'h784d);
    host_i.frame(1'b0, 2'b10, 5'h02, 5'h00, 16'h0000, v);
    chk("other address", v, 16'hffff);
    host_i.frame(1'b0, 2'b00, 5'h01, 5'h00, 16'h0000, v);
    wr(5'h00, 16'h0100);
    host_i.frame(1'b1, 2'b10, 5'h01, 5'h00, 16'h0000, v);
    chk("after bad opcode", v, 16'h0080);
  endtask

  // A second reset with the straps low: straps must be retaken and the
  // preamble demanded again before the first frame is answered.
  task automatic t_strap;
    logic [15:0] v;
    {strap_speed_100, strap_an_enable, strap_full_duplex} = 3'h0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    host_i.frame(1'b0, 2'b10, 5'h01, 5'h00, 16'h0000, v);
    chk("no preamble", v, 16'hffff);
    host_i.frame(1'b1, 2'b10, 5'h01, 5'h00, 16'h0000, v);
    chk("strapped control", v, 16'h0000);
    chk("strapped mode", 16'({port_speed_100, port_full_duplex}), 16'h0000);
  endtask

  task automatic results;
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Inputs start quiet and change only on falling edges.
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {tx_en, link_up, far_end_fault, partner_remote_fault, jabber_detected} = 5'h00;
    {an_done, an_started, an_speed_100, an_full_duplex} = 4'h1;
    {strap_speed_100, strap_an_enable, strap_full_duplex} = 3'h7;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_idle;
    t_restart;
    t_forced;
    t_iso;
    t_latch;
    t_refuse;
    t_strap;
    results;
  end

  // Some 28 frames take some 4000 cycles; five times that means a hang.
  initial begin
    #1000000;
    n_errors++;
    results;
  end
endmodule // test_phybmc_top
`default_nettype wire
